// file: hdl/css_defs.svh
// Register offsets, field positions, setting codes and initial values of the source selector
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

// Byte offsets of the pending settings bank (index times four)
`define CSS_ADDR_START 8'h00
`define CSS_ADDR_FREQ 8'h04
`define CSS_ADDR_NET 8'h08
`define CSS_ADDR_PU 8'h0C
`define CSS_ADDR_UGR 8'h10
`define CSS_ADDR_WP 8'h14
`define CSS_ADDR_OPM 8'h18
`define CSS_ADDR_STATUS 8'h1C
// Byte offset of the first word of the active (latched) bank
`define CSS_ADDR_ACT_BASE 8'h20

// Setting indexes inside each bank
`define CSS_IDX_START 3'h0
`define CSS_IDX_FREQ 3'h1
`define CSS_IDX_NET 3'h2
`define CSS_IDX_PU 3'h3
`define CSS_IDX_UGR 3'h4
`define CSS_IDX_WP 3'h5
`define CSS_IDX_OPM 3'h6
`define CSS_IDX_STATUS 3'h7
`define CSS_NUM_SET 7

// Setting codes
`define CSS_V0 16'h0000
`define CSS_V1 16'h0001
`define CSS_V2 16'h0002
`define CSS_AUTO 16'h270F

// Initial values
`define CSS_START_INIT 16'h0000
`define CSS_FREQ_INIT 16'h0000
`define CSS_NET_INIT 16'h270F
`define CSS_PU_INIT 16'h0002
`define CSS_UGR_INIT 16'h0000
`define CSS_WP_INIT 16'h0000
`define CSS_OPM_INIT 16'h0000

// Status register bit positions
`define CSS_ST_WREF 0
`define CSS_ST_MREF 1
`define CSS_ST_CARD 2
`define CSS_ST_CARD_LAT 3
`define CSS_ST_MODE_LO 4
`define CSS_ST_MODE_HI 5

`endif

// file: hdl/css_pkg.sv
// Types shared by the command source selector files
package css_pkg;

    // Command ports; the first four index the grant vectors
    typedef enum logic [2:0] {
        CSS_SRC_PANEL,
        CSS_SRC_RS485,
        CSS_SRC_CARD,
        CSS_SRC_TERM,
        CSS_SRC_NONE
    } css_src_t;

    // Operation modes
    typedef enum logic [1:0] {
        CSS_MODE_EXT,
        CSS_MODE_PU,
        CSS_MODE_NET
    } css_mode_t;

endpackage

// file: hdl/css_owner_decode.sv
// Decodes which port owns start, frequency and parameter writes from latched settings
`timescale 1ns/1ps
`include "css_defs.svh"

module css_owner_decode (
    input wire css_pkg::css_mode_t i_mode,
    input wire logic [15:0] i_start_sel,
    input wire logic [15:0] i_freq_sel,
    input wire logic [15:0] i_net_sel,
    input wire logic [15:0] i_pu_sel,
    input wire logic i_card_lat,
    output css_pkg::css_src_t o_net_owner,
    output css_pkg::css_src_t o_start_owner,
    output css_pkg::css_src_t o_freq_owner,
    output css_pkg::css_src_t o_write_owner
);

    css_pkg::css_src_t pu_owner;

    // Network and panel-unit mode owners
    always_comb begin
        if (i_net_sel == `CSS_V0) begin
            o_net_owner = css_pkg::CSS_SRC_CARD;
        end else if (i_net_sel == `CSS_V1) begin
            o_net_owner = css_pkg::CSS_SRC_RS485;
        end else if (i_card_lat) begin
            o_net_owner = css_pkg::CSS_SRC_CARD;
        end else begin
            o_net_owner = css_pkg::CSS_SRC_RS485;
        end
        pu_owner = (i_pu_sel == `CSS_V1) ? css_pkg::CSS_SRC_RS485 : css_pkg::CSS_SRC_PANEL;
    end

    // Per-command owners for the current mode
    always_comb begin
        unique case (i_mode)
            css_pkg::CSS_MODE_PU: begin
                o_start_owner = pu_owner;
                o_freq_owner = pu_owner;
                o_write_owner = pu_owner;
            end
            css_pkg::CSS_MODE_NET: begin
                o_start_owner = (i_start_sel == `CSS_V1) ? css_pkg::CSS_SRC_TERM : o_net_owner;
                o_freq_owner = (i_freq_sel == `CSS_V1) ? css_pkg::CSS_SRC_TERM : o_net_owner;
                o_write_owner = o_net_owner;
            end
            default: begin
                o_start_owner = css_pkg::CSS_SRC_TERM;
                o_freq_owner = css_pkg::CSS_SRC_TERM;
                o_write_owner = css_pkg::CSS_SRC_PANEL;
            end
        endcase
    end

endmodule // css_owner_decode

// file: hdl/css_selector.sv
// Command source selector: settings registers, reset latching, mode switching and grants
`timescale 1ns/1ps
`include "css_defs.svh"

// Contract
// - Start setting 0 takes start from communication, 1 from external terminals.
// - Frequency setting 0 communication, 1 terminals, 2 communication accepted, analog ignored.
// - In network mode, source setting 0 picks card, 1 picks RS-485 terminals.
// - Network source starts at automatic: RS-485 unless a card is detected.
// - In panel mode, setting 1 picks RS-485, 2 picks front panel; initial 2.
// - Automatic with card fitted: RS-485 writes, starts, frequencies refused; reads allowed.
// - Both sources on RS-485: panel mode wins; no card means network switch refused.
// - Written source settings take effect only at the next reset; a power-on reset loads the initial values instead.
// - Card selected for network mode but absent: entry to network mode refused.
// - No direct switch between panel mode and network mode.
// - Source settings writable only when user-group read is 0, or card present.
// - Network and panel source settings ignore the general write protection.
// - Automatic, panel source 2, no card: panel owns panel mode, RS-485 network.
// - Network source 1, panel source 2: card has no command authority.
// - Operation-mode setting: 0 external, 1 fixed panel, 2 external without panel.
module css_selector (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire logic I_POWER_ON,
    input wire logic I_CARD_FITTED,
    input wire logic [7:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_MODE_REQ,
    input wire logic [1:0] I_MODE_TARGET,
    input wire logic [3:0] I_START_REQ,
    input wire logic [3:0] I_FREQ_REQ,
    input wire logic [3:0] I_PWRITE_REQ,
    output logic [15:0] O_RDATA,
    output logic [1:0] O_OP_MODE,
    output logic [3:0] O_START_GRANT,
    output logic [3:0] O_FREQ_GRANT,
    output logic [3:0] O_PWRITE_GRANT,
    output logic O_ANALOG_FREQ_EN,
    output logic O_NET_SWITCH_OK,
    output logic O_PU_SWITCH_OK
);

    localparam logic [15:0] INIT_VAL [0:`CSS_NUM_SET-1] = '{
        `CSS_START_INIT, `CSS_FREQ_INIT, `CSS_NET_INIT, `CSS_PU_INIT,
        `CSS_UGR_INIT, `CSS_WP_INIT, `CSS_OPM_INIT
    };

    logic [15:0] pend_reg [0:`CSS_NUM_SET-1];
    logic [15:0] act_reg [0:`CSS_NUM_SET-1];
    logic card_meta_reg;
    logic card_sync_reg;
    logic card_lat_reg;
    logic wref_reg;
    logic mref_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [3:0] start_grant_reg;
    logic [3:0] freq_grant_reg;
    logic [3:0] pwrite_grant_reg;
    logic analog_en_reg;
    css_pkg::css_mode_t mode_reg;
    css_pkg::css_mode_t mode_next;
    css_pkg::css_mode_t target;
    css_pkg::css_src_t net_owner;
    css_pkg::css_src_t start_owner;
    css_pkg::css_src_t freq_owner;
    css_pkg::css_src_t write_owner;
    logic [3:0] start_mask;
    logic [3:0] freq_mask;
    logic [3:0] write_mask;
    logic [2:0] idx;
    logic bank_pend;
    logic bank_act;
    logic wr_set;
    logic wr_status;
    logic wr_allowed;
    logic wr_refused;
    logic net_ok;
    logic pu_ok;
    logic ext_ok;
    logic switch_ok;

    // Card presence pin passes two flops before use
    always_ff @(posedge I_CLOCK) begin
        card_meta_reg <= I_CARD_FITTED;
        card_sync_reg <= card_meta_reg;
    end

    // Card presence is recognised at reset and held until the next one
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            card_lat_reg <= card_sync_reg;
        end
    end

    // Address decode of the settings port
    assign idx = I_ADDR[4:2];
    assign bank_pend = (I_ADDR[7:5] == 3'h0) && (I_ADDR[1:0] == 2'h0);
    assign bank_act = (I_ADDR[7:5] == 3'h1) && (I_ADDR[1:0] == 2'h0) && (idx != `CSS_IDX_STATUS);
    assign wr_set = I_WR && bank_pend && (idx != `CSS_IDX_STATUS);
    assign wr_status = I_WR && bank_pend && (idx == `CSS_IDX_STATUS);

    // Write permission and setting range check
    always_comb begin
        wr_allowed = 1'b1;
        unique case (idx)
            `CSS_IDX_START, `CSS_IDX_FREQ: begin
                wr_allowed = (pend_reg[`CSS_IDX_UGR] == `CSS_V0) || card_sync_reg;
                if (pend_reg[`CSS_IDX_WP] == `CSS_V1) begin
                    wr_allowed = 1'b0;
                end
                if (idx == `CSS_IDX_START && I_WDATA > `CSS_V1) begin
                    wr_allowed = 1'b0;
                end
                if (idx == `CSS_IDX_FREQ && I_WDATA > `CSS_V2) begin
                    wr_allowed = 1'b0;
                end
            end
            `CSS_IDX_NET: begin
                // Protection setting deliberately not consulted here
                wr_allowed = (pend_reg[`CSS_IDX_UGR] == `CSS_V0) || card_sync_reg;
                if (I_WDATA > `CSS_V1 && I_WDATA != `CSS_AUTO) begin
                    wr_allowed = 1'b0;
                end
            end
            `CSS_IDX_PU: begin
                wr_allowed = (pend_reg[`CSS_IDX_UGR] == `CSS_V0) || card_sync_reg;
                if (I_WDATA != `CSS_V1 && I_WDATA != `CSS_V2) begin
                    wr_allowed = 1'b0;
                end
            end
            `CSS_IDX_WP, `CSS_IDX_OPM: begin
                wr_allowed = (I_WDATA <= `CSS_V2);
            end
            default: begin
                wr_allowed = 1'b1;
            end
        endcase
    end
    assign wr_refused = wr_set && !wr_allowed;

    // Pending settings take writes; active copies only change at reset
    for (genvar g = 0; g < `CSS_NUM_SET; g++) begin : g_set
        always_ff @(posedge I_CLOCK) begin
            if (I_SRST) begin
                if (I_POWER_ON) begin
                    pend_reg[g] <= INIT_VAL[g];
                    act_reg[g] <= INIT_VAL[g];
                end else begin
                    act_reg[g] <= pend_reg[g];
                end
            end else if (wr_set && wr_allowed && idx == 3'(g)) begin
                pend_reg[g] <= I_WDATA;
            end
        end
    end

    // Owner decode from the latched selections
    css_owner_decode u_decode (
        .i_mode(mode_reg),
        .i_start_sel(act_reg[`CSS_IDX_START]),
        .i_freq_sel(act_reg[`CSS_IDX_FREQ]),
        .i_net_sel(act_reg[`CSS_IDX_NET]),
        .i_pu_sel(act_reg[`CSS_IDX_PU]),
        .i_card_lat(card_lat_reg),
        .o_net_owner(net_owner),
        .o_start_owner(start_owner),
        .o_freq_owner(freq_owner),
        .o_write_owner(write_owner)
    );

    // One grant mask bit per port
    for (genvar p = 0; p < 4; p++) begin : g_port
        assign start_mask[p] = (start_owner == css_pkg::css_src_t'(3'(p)));
        assign freq_mask[p] = (freq_owner == css_pkg::css_src_t'(3'(p)));
        assign write_mask[p] = (write_owner == css_pkg::css_src_t'(3'(p)));
    end

    // Requests pass only from the owning port, one cycle later
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            start_grant_reg <= 4'h0;
            freq_grant_reg <= 4'h0;
            pwrite_grant_reg <= 4'h0;
        end else begin
            start_grant_reg <= I_START_REQ & start_mask;
            freq_grant_reg <= I_FREQ_REQ & freq_mask;
            pwrite_grant_reg <= I_PWRITE_REQ & write_mask;
        end
    end

    // Analog frequency input usable only when terminals own frequency
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            analog_en_reg <= 1'b0;
        end else begin
            analog_en_reg <= (freq_owner == css_pkg::CSS_SRC_TERM);
        end
    end

    // Which mode switches are allowed right now
    always_comb begin
        net_ok = 1'b1;
        pu_ok = 1'b1;
        ext_ok = 1'b1;
        if (mode_reg == css_pkg::CSS_MODE_PU) begin
            net_ok = 1'b0;
        end
        if (mode_reg == css_pkg::CSS_MODE_NET) begin
            pu_ok = 1'b0;
        end
        if (act_reg[`CSS_IDX_OPM] == `CSS_V2) begin
            pu_ok = 1'b0;
        end
        if (net_owner == css_pkg::CSS_SRC_CARD && !card_sync_reg) begin
            net_ok = 1'b0;
        end
        if (act_reg[`CSS_IDX_NET] == `CSS_V1 && act_reg[`CSS_IDX_PU] == `CSS_V1
            && !card_sync_reg) begin
            net_ok = 1'b0;
        end
        if (act_reg[`CSS_IDX_OPM] == `CSS_V1) begin
            net_ok = 1'b0;
            pu_ok = 1'b0;
            ext_ok = 1'b0;
        end
    end

    // Requested target and its acceptance
    assign target = css_pkg::css_mode_t'(I_MODE_TARGET);
    always_comb begin
        unique case (target)
            css_pkg::CSS_MODE_PU: switch_ok = pu_ok;
            css_pkg::CSS_MODE_NET: switch_ok = net_ok;
            css_pkg::CSS_MODE_EXT: switch_ok = ext_ok;
            default: switch_ok = 1'b0;
        endcase
        mode_next = (I_MODE_REQ && switch_ok) ? target : mode_reg;
    end

    // Mode at reset follows the operation-mode setting being latched
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            if (!I_POWER_ON && pend_reg[`CSS_IDX_OPM] == `CSS_V1) begin
                mode_reg <= css_pkg::CSS_MODE_PU;
            end else begin
                mode_reg <= css_pkg::CSS_MODE_EXT;
            end
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Sticky refusal flags; a new refusal wins over a clear
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            wref_reg <= 1'b0;
            mref_reg <= 1'b0;
        end else begin
            if (wr_refused) begin
                wref_reg <= 1'b1;
            end else if (wr_status && I_WDATA[`CSS_ST_WREF]) begin
                wref_reg <= 1'b0;
            end
            if (I_MODE_REQ && !switch_ok) begin
                mref_reg <= 1'b1;
            end else if (wr_status && I_WDATA[`CSS_ST_MREF]) begin
                mref_reg <= 1'b0;
            end
        end
    end

    // Read multiplexer; unmapped words read as zero
    always_comb begin
        rdata_next = 16'h0000;
        if (bank_pend && idx == `CSS_IDX_STATUS) begin
            rdata_next[`CSS_ST_WREF] = wref_reg;
            rdata_next[`CSS_ST_MREF] = mref_reg;
            rdata_next[`CSS_ST_CARD] = card_sync_reg;
            rdata_next[`CSS_ST_CARD_LAT] = card_lat_reg;
            rdata_next[`CSS_ST_MODE_HI:`CSS_ST_MODE_LO] = mode_reg;
        end else if (bank_pend) begin
            rdata_next = pend_reg[idx];
        end else if (bank_act) begin
            rdata_next = act_reg[idx];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= I_RD ? rdata_next : 16'h0000;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_OP_MODE = mode_reg;
    assign O_START_GRANT = start_grant_reg;
    assign O_FREQ_GRANT = freq_grant_reg;
    assign O_PWRITE_GRANT = pwrite_grant_reg;
    assign O_ANALOG_FREQ_EN = analog_en_reg;
    assign O_NET_SWITCH_OK = net_ok;
    assign O_PU_SWITCH_OK = pu_ok;

    // Terminal start granted in network mode with start setting 1
    property p_start_term;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (mode_reg == css_pkg::CSS_MODE_NET && act_reg[`CSS_IDX_START] == `CSS_V1
         && I_START_REQ[3]) |=> O_START_GRANT[3] && !O_START_GRANT[1];
    endproperty
    a_start_term: assert property (p_start_term) else $error("terminal start not granted");

    // Analog input off in network mode with frequency setting 2
    property p_freq_analog;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (mode_reg == css_pkg::CSS_MODE_NET && act_reg[`CSS_IDX_FREQ] == `CSS_V2)
        ##1 (mode_reg == css_pkg::CSS_MODE_NET) |-> !O_ANALOG_FREQ_EN;
    endproperty
    a_freq_analog: assert property (p_freq_analog) else $error("analog input not ignored");

    // RS-485 owns network mode when network source is 1
    property p_net_rs485;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (mode_reg == css_pkg::CSS_MODE_NET && act_reg[`CSS_IDX_NET] == `CSS_V1
         && I_PWRITE_REQ[1] && I_PWRITE_REQ[2]) |=> O_PWRITE_GRANT == 4'h2;
    endproperty
    a_net_rs485: assert property (p_net_rs485) else $error("RS-485 not network owner");

    // Automatic recognition with card: RS-485 commands refused
    property p_auto_card;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (mode_reg == css_pkg::CSS_MODE_NET && act_reg[`CSS_IDX_NET] == `CSS_AUTO
         && card_lat_reg) |=> !O_PWRITE_GRANT[1] && !O_START_GRANT[1] && !O_FREQ_GRANT[1];
    endproperty
    a_auto_card: assert property (p_auto_card) else $error("RS-485 command passed with card");

    // Panel owns panel mode when panel source is 2
    property p_pu_panel;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (mode_reg == css_pkg::CSS_MODE_PU && act_reg[`CSS_IDX_PU] == `CSS_V2
         && I_FREQ_REQ[0]) |=> O_FREQ_GRANT[0] && !O_FREQ_GRANT[1];
    endproperty
    a_pu_panel: assert property (p_pu_panel) else $error("panel frequency not granted");

    // Panel mode never jumps straight to network mode
    property p_no_direct;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (mode_reg == css_pkg::CSS_MODE_PU) |=> (mode_reg != css_pkg::CSS_MODE_NET);
    endproperty
    a_no_direct: assert property (p_no_direct) else $error("direct panel to network switch");

    // Absent card selected for network mode blocks entry
    property p_net_block;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (net_owner == css_pkg::CSS_SRC_CARD && !card_sync_reg
         && mode_reg != css_pkg::CSS_MODE_NET) |=> (mode_reg != css_pkg::CSS_MODE_NET);
    endproperty
    a_net_block: assert property (p_net_block) else $error("network mode without card");

    // Both sources on RS-485 without card keep network mode closed
    property p_both_rs485;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (act_reg[`CSS_IDX_NET] == `CSS_V1 && act_reg[`CSS_IDX_PU] == `CSS_V1 && !card_sync_reg
         && I_MODE_REQ && I_MODE_TARGET == 2'h2) |=> !$changed(mode_reg) && mref_reg;
    endproperty
    a_both_rs485: assert property (p_both_rs485) else $error("network switch not refused");

    // Accepted network source writes leave the active copy alone until reset
    property p_delayed;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (wr_set && wr_allowed && idx == `CSS_IDX_NET) |=> $stable(act_reg[`CSS_IDX_NET])
        && pend_reg[`CSS_IDX_NET] == $past(I_WDATA);
    endproperty
    a_delayed: assert property (p_delayed) else $error("setting applied before reset");

    // Locked user group and no card: source write refused and flagged
    property p_locked;
        @(posedge I_CLOCK) disable iff (I_SRST)
        (wr_set && idx == `CSS_IDX_PU && pend_reg[`CSS_IDX_UGR] != `CSS_V0 && !card_sync_reg)
        |=> $stable(pend_reg[`CSS_IDX_PU]) && wref_reg;
    endproperty
    a_locked: assert property (p_locked) else $error("locked source setting written");

endmodule // css_selector

// file: sim/css_port_model.sv
// Command ports model: option card presence pin and the four request sources
`timescale 1ns/1ps

module css_port_model #(
    parameter bit MODBUS_HOST = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_card_sel,
    input wire logic i_go,
    input wire logic [3:0] i_start,
    input wire logic [3:0] i_freq,
    input wire logic [3:0] i_write,
    input wire logic [1:0] i_mode,
    output logic o_card,
    output logic [3:0] o_start_req,
    output logic [3:0] o_freq_req,
    output logic [3:0] o_pwrite_req
);
    logic [3:0] host_mask;

    // A serial host speaking the industrial protocol stays silent in panel mode
    assign host_mask = (MODBUS_HOST && i_mode == 2'h1) ? 4'hD : 4'hF;

    // Card pin and one-cycle request pulses, launched after the clock edge
    always @(posedge i_clk) begin
        o_card <= i_card_sel;
        o_start_req <= i_go ? (i_start & host_mask) : 4'h0;
        o_freq_req <= i_go ? (i_freq & host_mask) : 4'h0;
        o_pwrite_req <= i_go ? (i_write & host_mask) : 4'h0;
    end
endmodule // css_port_model

// file: sim/css_selector_tb_top.sv
// Self-checking bench of the command source selector
`timescale 1ns/1ps

module css_selector_tb_top;
    logic I_CLOCK = 1'b0;
    logic I_SRST = 1'b1;
    logic I_POWER_ON = 1'b1;
    logic [7:0] I_ADDR = 8'h00;
    logic [15:0] I_WDATA = 16'h0000;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic I_MODE_REQ = 1'b0;
    logic [1:0] I_MODE_TARGET = 2'h0;
    logic card_fitted, card_sel = 1'b0, go = 1'b0;
    logic [3:0] s_vec = 4'h0, f_vec = 4'h0, w_vec = 4'h0;
    logic [3:0] start_req, freq_req, pwrite_req, start_gnt, freq_gnt, pwrite_gnt;
    logic [15:0] rdata;
    logic [1:0] op_mode;
    logic analog_en, net_ok, pu_ok, rd_q = 1'b0, rq_q = 1'b0;
    logic [15:0] exp_rd[$];
    logic [15:0] exp_gr[$];
    int n_mismatch = 0;
    int n_checks = 0;

    // Free-running 50 ns clock
    always #25 I_CLOCK = ~I_CLOCK;

    css_port_model i_ports (.i_clk(I_CLOCK), .i_card_sel(card_sel), .i_go(go),
        .i_start(s_vec), .i_freq(f_vec), .i_write(w_vec), .i_mode(op_mode),
        .o_card(card_fitted), .o_start_req(start_req), .o_freq_req(freq_req),
        .o_pwrite_req(pwrite_req));

    css_selector i_dut (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_POWER_ON(I_POWER_ON),
        .I_CARD_FITTED(card_fitted), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .I_MODE_REQ(I_MODE_REQ), .I_MODE_TARGET(I_MODE_TARGET),
        .I_START_REQ(start_req), .I_FREQ_REQ(freq_req), .I_PWRITE_REQ(pwrite_req),
        .O_RDATA(rdata), .O_OP_MODE(op_mode), .O_START_GRANT(start_gnt),
        .O_FREQ_GRANT(freq_gnt), .O_PWRITE_GRANT(pwrite_gnt), .O_ANALOG_FREQ_EN(analog_en),
        .O_NET_SWITCH_OK(net_ok), .O_PU_SWITCH_OK(pu_ok));

    // Compares one value and counts it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the verdict and ends the run
    task automatic stop_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Result watcher: read data and grants stand one cycle after their request
    always @(posedge I_CLOCK) begin
        if (rd_q) chk(rdata, exp_rd.pop_front());
        if (rq_q) chk({4'h0, start_gnt, freq_gnt, pwrite_gnt}, exp_gr.pop_front());
        rd_q <= I_RD & ~I_SRST;
        rq_q <= (|{start_req, freq_req, pwrite_req}) & ~I_SRST;
    end

    // Register bus write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge I_CLOCK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLOCK);
        I_WR <= 1'b0;
    endtask

    // Register bus read, expected word noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge I_CLOCK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        exp_rd.push_back(e);
        @(posedge I_CLOCK);
        I_RD <= 1'b0;
    endtask

    // Random requests from all ports; masks are the owners expected for start, freq, write
    task automatic gnt(input logic [3:0] ms, input logic [3:0] mf, input logic [3:0] mw);
        logic [3:0] s, f, w;
        // Fixed bits keep the guarded owner cases live; the other bits stay random
        s = 4'($urandom) | 4'h8;
        f = 4'($urandom) | 4'h1;
        w = 4'($urandom) | 4'h7;
        @(posedge I_CLOCK);
        go <= 1'b1;
        s_vec <= s;
        f_vec <= f;
        w_vec <= w;
        exp_gr.push_back({4'h0, s & ms, f & mf, w & mw});
        @(posedge I_CLOCK);
        go <= 1'b0;
        repeat (2) @(posedge I_CLOCK);
    endtask

    // Mode switch request, then mode compared one cycle later
    task automatic sw(input logic [1:0] t, input logic [1:0] e);
        @(posedge I_CLOCK);
        I_MODE_REQ <= 1'b1;
        I_MODE_TARGET <= t;
        @(posedge I_CLOCK);
        I_MODE_REQ <= 1'b0;
        @(posedge I_CLOCK);
        #1 chk({14'h0, op_mode}, {14'h0, e});
    endtask

    // Reset for six cycles, power-on or warm
    task automatic rst(input logic pon);
        @(posedge I_CLOCK);
        I_SRST <= 1'b1;
        I_POWER_ON <= pon;
        repeat (6) @(posedge I_CLOCK);
        I_SRST <= 1'b0;
        I_POWER_ON <= 1'b0;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge I_CLOCK);
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h5aee5006));
        rst(1'b1);
        rd(8'h00, 16'h0000);
        rd(8'h04, 16'h0000);
        rd(8'h08, 16'h270F);
        rd(8'h0C, 16'h0002);
        gnt(4'h8, 4'h8, 4'h1);
        sw(2'h2, 2'h2);
        gnt(4'h2, 4'h2, 4'h2);
        #1 chk({15'h0, pu_ok}, 16'h0000);
        sw(2'h1, 2'h2);
        rd(8'h1C, 16'h0022);
        wr(8'h1C, 16'h0003);
        sw(2'h0, 2'h0);
        sw(2'h1, 2'h1);
        gnt(4'h1, 4'h1, 4'h1);
        wr(8'h0C, 16'h0001);
        wr(8'h08, 16'h0001);
        rd(8'h2C, 16'h0002);
        rd(8'h0C, 16'h0001);
        rst(1'b0);
        #1 chk({15'h0, net_ok}, 16'h0000);
        sw(2'h2, 2'h0);
        sw(2'h1, 2'h1);
        gnt(4'h2, 4'h2, 4'h2);
        wr(8'h0C, 16'h0002);
        wr(8'h08, 16'h0000);
        rst(1'b0);
        sw(2'h0, 2'h0);
        #1 chk({15'h0, net_ok}, 16'h0000);
        sw(2'h2, 2'h0);
        card_sel <= 1'b1;
        wr(8'h08, 16'h270F);
        wr(8'h04, 16'h0002);
        rst(1'b0);
        sw(2'h2, 2'h2);
        gnt(4'h4, 4'h4, 4'h4);
        #1 chk({15'h0, analog_en}, 16'h0000);
        wr(8'h00, 16'h0001);
        wr(8'h04, 16'h0001);
        rst(1'b0);
        sw(2'h2, 2'h2);
        gnt(4'h8, 4'h8, 4'h4);
        #1 chk({15'h0, analog_en}, 16'h0001);
        wr(8'h1C, 16'h0003);
        wr(8'h14, 16'h0001);
        wr(8'h08, 16'h0001);
        wr(8'h00, 16'h0000);
        rd(8'h08, 16'h0001);
        rd(8'h00, 16'h0001);
        card_sel <= 1'b0;
        repeat (5) @(posedge I_CLOCK);
        wr(8'h10, 16'h0005);
        wr(8'h0C, 16'h0001);
        rd(8'h0C, 16'h0002);
        rd(8'h1C, 16'h0029);
        // Network source 1, panel source 2: RS-485 owns network mode, card has no say
        rst(1'b0);
        sw(2'h2, 2'h2);
        gnt(4'h8, 4'h8, 4'h2);
        // Operation-mode setting 2: panel mode closed after reset
        wr(8'h18, 16'h0002);
        rst(1'b0);
        #1 chk({15'h0, pu_ok}, 16'h0000);
        sw(2'h1, 2'h0);
        // Operation-mode setting 1: panel mode fixed from reset on
        wr(8'h18, 16'h0001);
        rst(1'b0);
        sw(2'h0, 2'h1);
        repeat (4) @(posedge I_CLOCK);
        stop_test();
    end
endmodule // css_selector_tb_top
